// File: plc_defs.svh
// Register offsets, reset values and widths for the parallel line controller.
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH
`define PLC_OFS_LINE_OWNERSHIP_STATUS 12'h008
`define PLC_OFS_OUTPUT_ENABLE_STATUS  12'h018
`define PLC_OFS_SET_OUTPUT_VALUE      12'h030
`define PLC_OFS_CLEAR_OUTPUT_VALUE    12'h034
`define PLC_OFS_OUTPUT_DATA_STATUS    12'h038
`define PLC_OFS_PIN_LEVEL_STATUS      12'h03c
`define PLC_OFS_CHANGE_IRQ_ENABLE     12'h040
`define PLC_OFS_CHANGE_IRQ_DISABLE    12'h044
`define PLC_OFS_CHANGE_IRQ_MASK       12'h048
`define PLC_OFS_CHANGE_IRQ_STATUS     12'h04c
`define PLC_OFS_OPEN_DRAIN_ENABLE     12'h050
`define PLC_OFS_OPEN_DRAIN_DISABLE    12'h054
`define PLC_OFS_OPEN_DRAIN_STATUS     12'h058
`define PLC_ADDR_W                    12
`define PLC_RST_OUTPUT_DATA           32'h0000_0000
`define PLC_RST_IRQ_MASK              32'h0000_0000
`define PLC_RST_IRQ_STATUS            32'h0000_0000
`define PLC_RST_OPEN_DRAIN            32'h0000_0000
`endif

// File: plc_pkg.sv
// Types shared by the parallel line controller files.
package plc_pkg;
	typedef logic [31:0] plc_word_t;
	typedef enum logic [1:0] {
		PLC_IDLE   = 2'b00,
		PLC_ACCESS = 2'b01
	} plc_phase_e;
	typedef struct packed {
		logic      pready;
		logic      pslverr;
		plc_word_t prdata;
	} plc_apb_rsp_s;
	typedef struct packed {
		plc_word_t out;
		plc_word_t oe;
	} plc_pad_s;
endpackage : plc_pkg

// File: plc_line_driver.sv
// Per-line pad driver: push-pull or open-drain output stage.
`timescale 1ns/100ps
`default_nettype none
module plc_line_driver #(
	parameter int N = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] owned,
	input  wire logic [N-1:0] out_en,
	input  wire logic [N-1:0] data,
	input  wire logic [N-1:0] open_drain,
	output var  logic [N-1:0] pad_out,
	output var  logic [N-1:0] pad_oe
);
	typedef struct packed {
		logic [N-1:0] out;
		logic [N-1:0] oe;
	} plc_drv_s;
	plc_drv_s st_r;
	plc_drv_s st_nxt;
	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < N; i++) begin
			if (owned[i] && out_en[i]) begin
				if (open_drain[i]) begin
					st_nxt.out[i] = 1'b0;
					st_nxt.oe[i]  = ~data[i];
				end else begin
					st_nxt.out[i] = data[i];
					st_nxt.oe[i]  = 1'b1;
				end
			end else begin
				st_nxt.out[i] = 1'b0;
				st_nxt.oe[i]  = 1'b0;
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign pad_out = st_r.out;
	assign pad_oe  = st_r.oe;
endmodule : plc_line_driver
`default_nettype wire

// File: plc_gpio.sv
// APB register block of the parallel line controller: output data, pin readback, change interrupts, open drain.
`timescale 1ns/100ps
`default_nettype none
`include "plc_defs.svh"
module plc_gpio #(
	parameter int N = 32
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [`PLC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	input  wire logic [N-1:0]          line_owned,
	input  wire logic [N-1:0]          line_out_en,
	input  wire logic [N-1:0]          pin_in,
	output var  logic [N-1:0]          pad_out,
	output var  logic [N-1:0]          pad_oe,
	output var  logic                  irq
);
	typedef struct packed {
		logic [N-1:0]        odata;
		logic [N-1:0]        mask;
		logic [N-1:0]        status;
		logic [N-1:0]        odrain;
		logic [N-1:0]        pin_q;
		logic                irq;
		plc_pkg::plc_apb_rsp_s rsp;
	} plc_state_s;
	plc_state_s st_r;
	plc_state_s st_nxt;
	logic       wr_go;
	logic       rd_go;
	logic [N-1:0] wbits;
	logic [N-1:0] edges;
	assign wr_go = psel && penable && pwrite && !st_r.rsp.pready;
	assign rd_go = psel && penable && !pwrite && !st_r.rsp.pready;
	assign wbits = pwdata[N-1:0];
	assign edges = pin_in ^ st_r.pin_q;
	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp.pready  = 1'b0;
		st_nxt.rsp.pslverr = 1'b0;
		st_nxt.rsp.prdata  = '0;
		st_nxt.pin_q = pin_in;
		if (wr_go) begin
			st_nxt.rsp.pready = 1'b1;
			case (paddr)
				`PLC_OFS_SET_OUTPUT_VALUE:   st_nxt.odata = st_r.odata | wbits;
				`PLC_OFS_CLEAR_OUTPUT_VALUE: st_nxt.odata = st_r.odata & ~wbits;
				`PLC_OFS_CHANGE_IRQ_ENABLE:  st_nxt.mask = st_r.mask | wbits;
				`PLC_OFS_CHANGE_IRQ_DISABLE: st_nxt.mask = st_r.mask & ~wbits;
				`PLC_OFS_OPEN_DRAIN_ENABLE:  st_nxt.odrain = st_r.odrain | wbits;
				`PLC_OFS_OPEN_DRAIN_DISABLE: st_nxt.odrain = st_r.odrain & ~wbits;
				default:                     st_nxt.rsp.pslverr = 1'b1;
			endcase
		end
		if (rd_go) begin
			st_nxt.rsp.pready = 1'b1;
			case (paddr)
				`PLC_OFS_LINE_OWNERSHIP_STATUS: st_nxt.rsp.prdata[N-1:0] = line_owned;
				`PLC_OFS_OUTPUT_ENABLE_STATUS:  st_nxt.rsp.prdata[N-1:0] = line_out_en;
				`PLC_OFS_OUTPUT_DATA_STATUS:    st_nxt.rsp.prdata[N-1:0] = st_r.odata;
				`PLC_OFS_PIN_LEVEL_STATUS:      st_nxt.rsp.prdata[N-1:0] = st_r.pin_q;
				`PLC_OFS_CHANGE_IRQ_MASK:       st_nxt.rsp.prdata[N-1:0] = st_r.mask;
				`PLC_OFS_CHANGE_IRQ_STATUS:     st_nxt.rsp.prdata[N-1:0] = st_r.status;
				`PLC_OFS_OPEN_DRAIN_STATUS:     st_nxt.rsp.prdata[N-1:0] = st_r.odrain;
				default:                        st_nxt.rsp.pslverr = 1'b1;
			endcase
		end
		if (rd_go && paddr == `PLC_OFS_CHANGE_IRQ_STATUS) begin
			st_nxt.status = '0;
		end
		st_nxt.status = st_nxt.status | edges;
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
	end
	// Pin sampling starts from zero, so a pin high at reset release reports one change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.odata  <= `PLC_RST_OUTPUT_DATA;
			st_r.mask   <= `PLC_RST_IRQ_MASK;
			st_r.status <= `PLC_RST_IRQ_STATUS;
			st_r.odrain <= `PLC_RST_OPEN_DRAIN;
			st_r.pin_q  <= '0;
			st_r.irq    <= 1'b0;
			st_r.rsp    <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	plc_line_driver #(.N(N)) u_drv (
		.clk        (pclk),
		.rst_n      (presetn),
		.owned      (line_owned),
		.out_en     (line_out_en),
		.data       (st_r.odata),
		.open_drain (st_r.odrain),
		.pad_out    (pad_out),
		.pad_oe     (pad_oe)
	);
	assign prdata  = st_r.rsp.prdata;
	assign pready  = st_r.rsp.pready;
	assign pslverr = st_r.rsp.pslverr;
	assign irq     = st_r.irq;
endmodule : plc_gpio
`default_nettype wire

// File: plc_chk.sv
// Port checker for the parallel line controller.
`timescale 1ns/100ps
`default_nettype none
module plc_chk #(
	parameter int N = 32
) (
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [11:0]  paddr,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic [N-1:0] line_owned,
	input wire logic [N-1:0] line_out_en,
	input wire logic [N-1:0] pad_oe,
	input wire logic         irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic rd = pready && !pwrite;
	// The mask write drops the request in the same cycle as the status read would, with pready.
	wire logic clr = (rd && paddr == 12'h04c) || (pready && pwrite && paddr == 12'h044);
	ready_once_a: assert property (pready |=> !pready) else $error("ready too long");
	ready_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
	err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
	pad_owned_a: assert property (1 |=> (pad_oe & ~$past(line_owned & line_out_en)) == '0) else $error("pad");
	own_read_a: assert property (rd && paddr == 12'h008 |-> prdata[N-1:0] == $past(line_owned)) else $error("own");
	wo_read_a: assert property (rd && paddr == 12'h044 |-> pslverr && prdata == 32'h0) else $error("wo read");
	irq_fall_a: assert property ($fell(irq) |-> clr || $past(clr)) else $error("irq fell");
endmodule : plc_chk
`default_nettype wire

// File: plc_pins.sv
// Pin model: pads resolved against an outside driver and a pull-up.
`timescale 1ns/100ps
`default_nettype none
module plc_pins (
	input  wire logic [31:0] pad_out,
	input  wire logic [31:0] pad_oe,
	input  wire logic [31:0] ext_en,
	input  wire logic [31:0] ext_val,
	output var  logic [31:0] pin
);
	assign pin = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | ~ext_en));
endmodule : plc_pins
`default_nettype wire

// File: test_gpio_status_irq_opendrain.sv
// Self-checking bench for the parallel line controller.
`timescale 1ns/100ps
`default_nettype none
module test_gpio_status_irq_opendrain;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, line_owned = 32'h0, line_out_en = 32'h0, ext_val = 32'h0;
	logic [31:0] ext_en = 32'hffff_ffff;
	logic [31:0] prdata, pad_out, pad_oe, pin_in, q, od, md, mk, s, c, m, v, p, rs;
	logic        pready, pslverr, irq;
	int          failures = 0, num_checks = 0;
	always #25 pclk = ~pclk;
	plc_gpio #(.N(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_owned(line_owned), .line_out_en(line_out_en), .pin_in(pin_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .irq(irq));
	plc_pins pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en), .ext_val(ext_val), .pin(pin_in));
	function automatic logic [31:0] rnd();
		for (int i = 0; i < 9; i++)
			rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
		return rs;
	endfunction : rnd
	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, x);
		num_checks++;
		if (g !== x) begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	// Code bit 1 skips the data compare, bit 0 is the expected error flag.
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, x, input logic [1:0] k);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		if (pready !== 1'b1) begin
			failures++;
			conclude();
		end
		q = prdata;
		chk({31'h0, pslverr}, {31'h0, k[0]});
		psel <= 1'b0;
		penable <= 1'b0;
		if (!w && !k[1])
			chk(q, x);
	endtask : acc
	initial begin
		rs = 32'h0000_7700;
		od = 32'h0;
		md = 32'h0;
		mk = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, 12'h038, 0, 0, 2'b00);
		acc(1'b0, 12'h048, 0, 0, 2'b00);
		acc(1'b0, 12'h04c, 0, 0, 2'b00);
		acc(1'b0, 12'h058, 0, 0, 2'b00);
		repeat (4) begin
			s = rnd();
			c = rnd();
			m = rnd();
			acc(1'b1, 12'h030, s, 0, 2'b00);
			acc(1'b1, 12'h034, c, 0, 2'b00);
			od = (od | s) & ~c;
			acc(1'b0, 12'h038, 0, od, 2'b00);
			acc(1'b1, 12'h050, m, 0, 2'b00);
			acc(1'b1, 12'h054, c, 0, 2'b00);
			md = (md | m) & ~c;
			acc(1'b0, 12'h058, 0, md, 2'b00);
			acc(1'b1, 12'h040, m, 0, 2'b00);
			acc(1'b1, 12'h044, c, 0, 2'b00);
			mk = (mk | m) & ~c;
			acc(1'b0, 12'h048, 0, mk, 2'b00);
			s = rnd();
			v = rnd();
			line_owned <= s;
			line_out_en <= v;
			repeat (2) @(posedge pclk);
			#1;
			chk(pad_oe, s & v & ~(md & od));
			chk(pad_out & pad_oe, s & v & od & ~md);
			line_out_en <= 32'h0;
			p = ext_val;
			repeat (3) @(posedge pclk);
			acc(1'b0, 12'h04c, 0, 0, 2'b10);
			v = rnd();
			ext_val <= v;
			repeat (3) @(posedge pclk);
			acc(1'b0, 12'h03c, 0, v, 2'b00);
			chk({31'h0, irq}, {31'h0, |((p ^ v) & mk)});
			acc(1'b0, 12'h04c, 0, p ^ v, 2'b00);
			acc(1'b0, 12'h04c, 0, 0, 2'b00);
			chk({31'h0, irq}, 32'h0);
		end
		acc(1'b0, 12'h008, 0, s, 2'b00);
		acc(1'b0, 12'h018, 0, 0, 2'b00);
		acc(1'b1, 12'h038, rnd(), 0, 2'b01);
		acc(1'b0, 12'h038, 0, od, 2'b00);
		acc(1'b0, 12'h100, 0, 0, 2'b01);
		acc(1'b0, 12'h044, 0, 0, 2'b01);
		conclude();
	end
endmodule : test_gpio_status_irq_opendrain
bind plc_gpio plc_chk #(.N(N)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.line_owned(line_owned), .line_out_en(line_out_en), .pad_oe(pad_oe), .irq(irq));
`default_nettype wire
